// ==== include/onoff_pkg.sv ====
// Package for the PMBus on/off, margin, write-lock and config-store block.
// Assumes a 100 MHz clock and a front end that delivers decoded command frames.
package onoff_pkg;

  localparam int CLK_MHZ = 100;
  localparam int NUM_CH  = 6;

  // Command codes.
  localparam logic [7:0] CMD_PAGE        = 8'h00;
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] CMD_CLEAR       = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_FEATURE     = 8'h19;

  // OPERATION codes.
  localparam logic [7:0] OP_OFF_NOW  = 8'h00;
  localparam logic [7:0] OP_OFF_SOFT = 8'h40;
  localparam logic [7:0] OP_ON       = 8'h80;
  localparam logic [7:0] OP_LOW_IGN  = 8'h94;
  localparam logic [7:0] OP_LOW_ACT  = 8'h98;
  localparam logic [7:0] OP_HIGH_IGN = 8'hA4;
  localparam logic [7:0] OP_HIGH_ACT = 8'hA8;

  // On/off configuration fields.
  localparam int CFG_BIAS_BIT = 4;
  localparam int CFG_OP_BIT   = 3;
  localparam int CFG_PIN_BIT  = 2;
  localparam int CFG_POL_BIT  = 1;
  localparam int CFG_IMM_BIT  = 0;
  localparam logic [7:0] CFG_USED_MASK = 8'h1F;

  // Write-lock levels.
  localparam logic [7:0] LOCK_ALL    = 8'h80;
  localparam logic [7:0] LOCK_OP     = 8'h40;
  localparam logic [7:0] LOCK_CFG    = 8'h20;
  localparam logic [7:0] LOCK_NONE   = 8'h00;

  // Reset values and page codes.
  localparam logic [7:0] CFG_DEFAULT  = 8'h16;
  localparam logic [7:0] PAGE_RESET   = 8'h00;
  localparam logic [7:0] PAGE_ALL     = 8'hFF;
  localparam logic [7:0] OP_RESET     = 8'h00;

  // Feature report fields.
  localparam logic       FEAT_PEC    = 1'b0;
  localparam logic [1:0] FEAT_SPEED  = 2'b00;
  localparam logic [3:0] FEAT_RSVD   = 4'h0;

  // Timing.
  localparam int TOFF_DELAY_US  = 1000;
  localparam int TOFF_CYCLES    = TOFF_DELAY_US * CLK_MHZ;
  localparam int STORE_TIME_US  = 10000;
  localparam int STORE_CYCLES   = STORE_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic [7:0] on_off;
    logic [7:0] lock;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_RESTORE,
    ST_IDLE,
    ST_STORE
  } state_t;

endpackage

// ==== logic/config_store.sv ====
// Nonvolatile copy of the configuration with a timed store operation.
// Assumes the caller holds off other work while o_busy is high.
`timescale 1ns/1ps
module config_store #(
  parameter int STORE_CYCLES = onoff_pkg::STORE_CYCLES
) (
  input  wire logic            i_clock,
  input  wire logic            i_sys_rst,
  input  wire logic            i_store_start,
  input  wire onoff_pkg::cfg_t i_store_data,
  input  wire logic            i_supply_low,
  output logic                 o_busy,
  output logic                 o_fail,
  output onoff_pkg::cfg_t      o_saved
);

  logic [31:0] cnt_q;
  logic        fail_seen_q;
  logic        last;
  onoff_pkg::cfg_t image_q = '{on_off: onoff_pkg::CFG_DEFAULT, lock: onoff_pkg::LOCK_NONE};

  assign last = o_busy && (cnt_q == 32'(STORE_CYCLES - 1));

  // Counts the store time and tracks a supply dip during it.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_busy      <= 1'b0;
      cnt_q       <= 32'h0;
      fail_seen_q <= 1'b0;
    end else if (i_store_start && !o_busy) begin
      o_busy      <= 1'b1;
      cnt_q       <= 32'h0;
      fail_seen_q <= i_supply_low;
    end else if (o_busy) begin
      fail_seen_q <= fail_seen_q | i_supply_low;
      if (cnt_q == 32'(STORE_CYCLES - 1)) begin
        o_busy <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  // Flags a store that saw the supply dip.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fail <= 1'b0;
    end else begin
      o_fail <= last && (fail_seen_q || i_supply_low);
    end
  end

  // The image is nonvolatile, so the system reset leaves it alone.
  always_ff @(posedge i_clock) begin
    if (last && !fail_seen_q && !i_supply_low) begin
      image_q <= i_store_data;
    end
  end

  assign o_saved = image_q;

endmodule

// ==== logic/pmbus_onoff_protect_config.sv ====
// PMBus command handling for supply on/off, margin, write lock and config store.
// Assumes a front end that delivers one decoded command per i_cmd_valid pulse.
// Functional notes
// - With command enabled, 00h off now, 40h off after delay, 80h on.
// - Unlisted OPERATION byte sets communication fault and raises alert.
// - Command-enable bit clear ignores on/off part, keeps margin part.
// - Margin codes 80h off, 94h/98h low, A4h/A8h high, ignore or act.
// - Margining waits until every enabled channel reports power good.
// - With on/off part ignored, margin acts only on an enabled supply.
// - Config bit 4 low turns supplies on once bias is present.
// - Config bit 4 high obeys only the CONTROL pin and OPERATION.
// - Config bit 3 high requires an OPERATION on before turn-on.
// - Config bit 2 high makes the CONTROL pin required; low ignores it.
// - Polarity 0 turns on with pin low, 1 turns on with pin high.
// - Config bit 0 picks soft or immediate off when CONTROL turns off.
// - CLEAR_FAULTS has no data and clears all status bits together.
// - Clearing faults never restarts or changes the supply enables.
// - A fault still present after clearing sets again and alerts.
// - Lock levels 80h, 40h, 20h, 00h gate which writes are accepted.
// - Reads of supported commands work at any lock level.
// - Writes to locked commands are dropped without any fault.
// - Store-all saves configuration only, not status or operation.
// - Failed store sets communication fault and alerts if enabled.
// - During a store, commands are refused and monitoring halts.
// - Restore-all and every reset load the saved configuration.
// - Feature byte reads no PEC, 100kHz, reserved low nibble zero.
// - Feature bit 4 mirrors the alert enable of the vendor mode setting.
`timescale 1ns/1ps
module pmbus_onoff_protect_config #(
  parameter int TOFF_CYCLES  = onoff_pkg::TOFF_CYCLES,
  parameter int STORE_CYCLES = onoff_pkg::STORE_CYCLES
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_cmd_valid,
  input  wire onoff_pkg::cmd_t            i_cmd,
  output logic                            o_cmd_ready,
  output logic                            o_rd_valid,
  output logic [7:0]                      o_rd_data,
  input  wire logic                       i_control_pin,
  input  wire logic                       i_bias_ok,
  input  wire logic [onoff_pkg::NUM_CH-1:0] i_pgood_on,
  input  wire logic [onoff_pkg::NUM_CH-1:0] i_fault_present,
  input  wire logic [onoff_pkg::NUM_CH-1:0] i_fault_latch_off,
  input  wire logic                       i_alert_enable,
  input  wire logic                       i_supply_low,
  output logic [onoff_pkg::NUM_CH-1:0]    o_supply_enable_output,
  output logic [onoff_pkg::NUM_CH-1:0]    o_margin_low,
  output logic [onoff_pkg::NUM_CH-1:0]    o_margin_high,
  output logic [onoff_pkg::NUM_CH-1:0]    o_margin_act_fault,
  output logic                            o_status_cml,
  output logic                            o_status_fault,
  output logic                            o_alert
);

  localparam int N = onoff_pkg::NUM_CH;

  onoff_pkg::state_t state_q;
  onoff_pkg::cfg_t   cfg_q;
  onoff_pkg::cfg_t   saved;
  logic [7:0]        page_q;
  logic [7:0]        op_q [N];
  logic [31:0]       off_cnt_q [N];
  logic [N-1:0]      latch_q;
  logic [1:0]        ctrl_sync_q;
  logic [1:0]        bias_sync_q;
  logic              store_busy;
  logic              store_fail;
  logic              store_start;
  logic              take;
  logic              wr;
  logic              rd;
  logic              monitor;
  logic              pin_on;
  logic              op_bad;
  logic              clear;
  logic [N-1:0]      sel;
  logic [N-1:0]      want;
  logic [N-1:0]      imm_off;
  logic              margin_ok;

  // Write acceptance for the current lock level.
  function automatic logic write_allowed(input logic [7:0] code, input logic [7:0] lock);
    logic ok;
    ok = 1'b1;
    if (lock[7]) begin
      ok = (code == onoff_pkg::CMD_WRITE_LOCK);
    end else if (lock[6]) begin
      ok = (code == onoff_pkg::CMD_WRITE_LOCK) || (code == onoff_pkg::CMD_OPERATION) ||
           (code == onoff_pkg::CMD_PAGE);
    end else if (lock[5]) begin
      ok = (code == onoff_pkg::CMD_WRITE_LOCK) || (code == onoff_pkg::CMD_OPERATION) ||
           (code == onoff_pkg::CMD_PAGE) || (code == onoff_pkg::CMD_ON_OFF_CFG);
    end
    return ok;
  endfunction

  // True for any listed OPERATION byte.
  function automatic logic op_valid(input logic [7:0] v);
    return (v == onoff_pkg::OP_OFF_NOW) || (v == onoff_pkg::OP_OFF_SOFT) ||
           (v == onoff_pkg::OP_ON) || (v == onoff_pkg::OP_LOW_IGN) ||
           (v == onoff_pkg::OP_LOW_ACT) || (v == onoff_pkg::OP_HIGH_IGN) ||
           (v == onoff_pkg::OP_HIGH_ACT);
  endfunction

  config_store #(
    .STORE_CYCLES (STORE_CYCLES)
  ) u_store (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .i_store_start (store_start),
    .i_store_data  (cfg_q),
    .i_supply_low  (i_supply_low),
    .o_busy        (store_busy),
    .o_fail        (store_fail),
    .o_saved       (saved)
  );

  // Pin synchronisers.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_sync_q <= 2'b00;
      bias_sync_q <= 2'b00;
    end else begin
      ctrl_sync_q <= {ctrl_sync_q[0], i_control_pin};
      bias_sync_q <= {bias_sync_q[0], i_bias_ok};
    end
  end

  assign o_cmd_ready = (state_q == onoff_pkg::ST_IDLE);
  assign take        = i_cmd_valid && o_cmd_ready;
  assign wr          = take && i_cmd.write;
  assign rd          = take && !i_cmd.write;
  assign monitor     = (state_q != onoff_pkg::ST_STORE);
  assign store_start = wr && (i_cmd.code == onoff_pkg::CMD_STORE_ALL) &&
                       write_allowed(i_cmd.code, cfg_q.lock);
  assign clear       = wr && (i_cmd.code == onoff_pkg::CMD_CLEAR) &&
                       write_allowed(i_cmd.code, cfg_q.lock);
  assign op_bad      = wr && (i_cmd.code == onoff_pkg::CMD_OPERATION) &&
                       write_allowed(i_cmd.code, cfg_q.lock) && !op_valid(i_cmd.data);

  // Level of the CONTROL pin that means on.
  assign pin_on = ctrl_sync_q[1] == cfg_q.on_off[onoff_pkg::CFG_POL_BIT];

  // Sequencer: restore after reset, idle, store.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= onoff_pkg::ST_RESTORE;
    end else begin
      case (state_q)
        onoff_pkg::ST_RESTORE: begin
          state_q <= onoff_pkg::ST_IDLE;
        end
        onoff_pkg::ST_IDLE: begin
          if (store_start) begin
            state_q <= onoff_pkg::ST_STORE;
          end
        end
        onoff_pkg::ST_STORE: begin
          if (!store_busy && state_q == onoff_pkg::ST_STORE && !store_start) begin
            state_q <= onoff_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= onoff_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Working configuration registers.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q <= '{on_off: onoff_pkg::CFG_DEFAULT, lock: onoff_pkg::LOCK_NONE};
    end else if (state_q == onoff_pkg::ST_RESTORE) begin
      cfg_q <= saved;
    end else if (wr && write_allowed(i_cmd.code, cfg_q.lock)) begin
      if (i_cmd.code == onoff_pkg::CMD_RESTORE_ALL) begin
        cfg_q <= saved;
      end else if (i_cmd.code == onoff_pkg::CMD_ON_OFF_CFG) begin
        cfg_q.on_off <= i_cmd.data & onoff_pkg::CFG_USED_MASK;
      end else if (i_cmd.code == onoff_pkg::CMD_WRITE_LOCK) begin
        cfg_q.lock <= i_cmd.data;
      end
    end
  end

  // Page selection.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      page_q <= onoff_pkg::PAGE_RESET;
    end else if (wr && i_cmd.code == onoff_pkg::CMD_PAGE &&
                 write_allowed(i_cmd.code, cfg_q.lock)) begin
      page_q <= i_cmd.data;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      sel[i] = (page_q == onoff_pkg::PAGE_ALL) || (page_q == 8'(i));
    end
  end

  // Per-channel OPERATION byte.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < N; i++) begin
        op_q[i] <= onoff_pkg::OP_RESET;
      end
    end else if (wr && i_cmd.code == onoff_pkg::CMD_OPERATION &&
                 write_allowed(i_cmd.code, cfg_q.lock) && op_valid(i_cmd.data)) begin
      for (int i = 0; i < N; i++) begin
        if (sel[i] && (cfg_q.on_off[onoff_pkg::CFG_OP_BIT] ||
                       o_supply_enable_output[i])) begin
          op_q[i] <= i_cmd.data;
        end
      end
    end
  end

  // Turn-on demand per channel.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!cfg_q.on_off[onoff_pkg::CFG_BIAS_BIT]) begin
        want[i] = bias_sync_q[1];
      end else begin
        want[i] = (!cfg_q.on_off[onoff_pkg::CFG_OP_BIT] || op_q[i][7]) &&
                  (!cfg_q.on_off[onoff_pkg::CFG_PIN_BIT] || pin_on);
      end
      imm_off[i] = (cfg_q.on_off[onoff_pkg::CFG_OP_BIT] &&
                    op_q[i] == onoff_pkg::OP_OFF_NOW) ||
                   (cfg_q.on_off[onoff_pkg::CFG_PIN_BIT] && !pin_on &&
                    cfg_q.on_off[onoff_pkg::CFG_IMM_BIT]);
    end
  end

  // Fault latch-off: held until the channel is commanded off.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      latch_q <= '0;
    end else begin
      latch_q <= (latch_q & want) | (i_fault_latch_off & {N{monitor}});
    end
  end

  // Supply enables with soft-off delay.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_supply_enable_output <= '0;
      for (int i = 0; i < N; i++) begin
        off_cnt_q[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (latch_q[i]) begin
          o_supply_enable_output[i] <= 1'b0;
          off_cnt_q[i]              <= 32'h0;
        end else if (want[i]) begin
          o_supply_enable_output[i] <= 1'b1;
          off_cnt_q[i]              <= 32'h0;
        end else if (o_supply_enable_output[i]) begin
          if (imm_off[i] || off_cnt_q[i] == 32'(TOFF_CYCLES - 1)) begin
            o_supply_enable_output[i] <= 1'b0;
            off_cnt_q[i]              <= 32'h0;
          end else begin
            off_cnt_q[i] <= off_cnt_q[i] + 32'h1;
          end
        end
      end
    end
  end

  // Margin low/high outputs, held back until all enabled channels are good; act-fault follows OPERATION only.
  assign margin_ok = ((i_pgood_on & o_supply_enable_output) == o_supply_enable_output);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_margin_low       <= '0;
      o_margin_high      <= '0;
      o_margin_act_fault <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        o_margin_low[i]       <= margin_ok && o_supply_enable_output[i] &&
                                 (op_q[i] == onoff_pkg::OP_LOW_IGN ||
                                  op_q[i] == onoff_pkg::OP_LOW_ACT);
        o_margin_high[i]      <= margin_ok && o_supply_enable_output[i] &&
                                 (op_q[i] == onoff_pkg::OP_HIGH_IGN ||
                                  op_q[i] == onoff_pkg::OP_HIGH_ACT);
        o_margin_act_fault[i] <= op_q[i] == onoff_pkg::OP_LOW_ACT ||
                                 op_q[i] == onoff_pkg::OP_HIGH_ACT;
      end
    end
  end

  // Status bits: a new event in the clearing cycle wins.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_status_cml   <= 1'b0;
      o_status_fault <= 1'b0;
    end else begin
      o_status_cml   <= (o_status_cml && !clear) || op_bad || store_fail;
      o_status_fault <= (o_status_fault && !clear) ||
                        (monitor && |i_fault_present);
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_alert <= 1'b0;
    end else begin
      o_alert <= i_alert_enable && (o_status_cml || o_status_fault);
    end
  end

  // Read answers, never gated by the lock level.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= rd;
      if (rd) begin
        if (i_cmd.code == onoff_pkg::CMD_PAGE) begin
          o_rd_data <= page_q;
        end else if (i_cmd.code == onoff_pkg::CMD_OPERATION) begin
          o_rd_data <= op_q[(page_q < 8'(N)) ? 3'(page_q) : 3'h0];
        end else if (i_cmd.code == onoff_pkg::CMD_ON_OFF_CFG) begin
          o_rd_data <= cfg_q.on_off & onoff_pkg::CFG_USED_MASK;
        end else if (i_cmd.code == onoff_pkg::CMD_WRITE_LOCK) begin
          o_rd_data <= cfg_q.lock;
        end else if (i_cmd.code == onoff_pkg::CMD_FEATURE) begin
          o_rd_data <= {onoff_pkg::FEAT_PEC, onoff_pkg::FEAT_SPEED, i_alert_enable,
                        onoff_pkg::FEAT_RSVD};
        end else begin
          o_rd_data <= 8'h00;
        end
      end
    end
  end

endmodule

// ==== tb/onoff_asserts.sv ====
// Checker for the on/off, margin, write-lock and store block.
// Sees only the top module ports; attached by the bind at the foot.
`timescale 1ns/1ps
module onoff_asserts (
  input wire logic                         i_clock,
  input wire logic                         i_sys_rst,
  input wire logic                         i_cmd_valid,
  input wire onoff_pkg::cmd_t              i_cmd,
  input wire logic                         o_cmd_ready,
  input wire logic                         o_rd_valid,
  input wire logic [7:0]                   o_rd_data,
  input wire logic [onoff_pkg::NUM_CH-1:0] i_fault_present,
  input wire logic                         i_alert_enable,
  input wire logic                         i_supply_low,
  input wire logic [onoff_pkg::NUM_CH-1:0] o_supply_enable_output,
  input wire logic                         o_status_cml,
  input wire logic                         o_status_fault,
  input wire logic                         o_alert
);
  logic       tk;
  logic       wr;
  logic       bad_op;
  logic [7:0] lock_q;
  logic       low_q;
  assign tk = i_cmd_valid && o_cmd_ready;
  assign wr = tk && i_cmd.write;
  assign bad_op = !(i_cmd.data inside {8'h00, 8'h40, 8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8});
  // Shadow of the write-lock level as accepted at the port.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock_q <= 8'h00;
    end else if (wr && i_cmd.code == onoff_pkg::CMD_WRITE_LOCK) begin
      lock_q <= i_cmd.data;
    end
  end
  // Remembers a low supply seen while the port was busy.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_q <= 1'b0;
    end else if (o_cmd_ready) begin
      low_q <= 1'b0;
    end else if (i_supply_low) begin
      low_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  AST_READ_ANS: assert property (tk && !i_cmd.write |=> o_rd_valid)
    else $error("read not answered");
  AST_FEAT: assert property (tk && !i_cmd.write && i_cmd.code == onoff_pkg::CMD_FEATURE
    |=> o_rd_data == {3'b000, $past(i_alert_enable), 4'h0}) else $error("feature byte wrong");
  AST_REFUSE: assert property (i_cmd_valid && !o_cmd_ready |=> !o_rd_valid)
    else $error("command taken while busy");
  AST_BAD_OP: assert property (wr && i_cmd.code == onoff_pkg::CMD_OPERATION && bad_op
    && !lock_q[7] |=> o_status_cml) else $error("invalid operation not flagged");
  AST_DROP_SILENT: assert property (wr && lock_q[7] && i_cmd.code != 8'h10
    |=> !$rose(o_status_cml)) else $error("locked write raised a fault");
  AST_CLEAR_ALL: assert property (wr && i_cmd.code == onoff_pkg::CMD_CLEAR && lock_q == 8'h00
    && i_fault_present == '0 |=> !o_status_cml && !o_status_fault) else $error("clear incomplete");
  AST_CLEAR_EN: assert property (wr && i_cmd.code == onoff_pkg::CMD_CLEAR
    |=> $stable(o_supply_enable_output)[*2]) else $error("clear moved enables");
  AST_REFAULT: assert property (|i_fault_present |=> o_status_fault)
    else $error("present fault not reported");
  AST_ALERT: assert property (o_alert == $past(i_alert_enable && (o_status_cml || o_status_fault)))
    else $error("alert does not follow status");
  AST_STORE_HOLD: assert property (wr && i_cmd.code == onoff_pkg::CMD_STORE_ALL && lock_q == 8'h00
    |=> (!o_cmd_ready)[*4] ##[1:40] o_cmd_ready) else $error("store busy window wrong");
  AST_STORE_FAIL: assert property ($rose(o_cmd_ready) && low_q |-> ##[0:3] o_status_cml)
    else $error("failed store not flagged");
  COV_STORE: cover property (wr && i_cmd.code == onoff_pkg::CMD_STORE_ALL);
  COV_BAD_OP: cover property (wr && i_cmd.code == onoff_pkg::CMD_OPERATION && bad_op);
  COV_FEAT: cover property (tk && !i_cmd.write && i_cmd.code == onoff_pkg::CMD_FEATURE);
endmodule

bind pmbus_onoff_protect_config onoff_asserts chk_u (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .i_fault_present(i_fault_present), .i_alert_enable(i_alert_enable),
  .i_supply_low(i_supply_low), .o_supply_enable_output(o_supply_enable_output),
  .o_status_cml(o_status_cml), .o_status_fault(o_status_fault), .o_alert(o_alert));

// ==== tb/pmbus_host_model.sv ====
// Host model for the command port: one command per call, read answer collected.
// Assumes a single calling process.
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_ready,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic            o_valid,
  output onoff_pkg::cmd_t o_cmd
);
  initial begin
    o_valid = 1'b0;
    o_cmd = '0;
  end
  // Holds the request from a falling edge through the taking rising edge.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] r, output logic ok);
    int n;
    n = 0;
    @(negedge i_clock);
    o_valid = 1'b1;
    o_cmd = '{write: w, code: c, data: d};
    while (!i_ready && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    @(posedge i_clock);
    @(negedge i_clock);
    ok = (n < 200) && (w || i_rd_valid === 1'b1);
    r = i_rd_data;
    o_valid = 1'b0;
    o_cmd = ~o_cmd;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Testbench: command-port tasks and sequences with expected values.
// Assumes shortened soft-off and store counts.
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0, rst = 1'b1, pin = 1'b0, bias = 1'b1, aen = 1'b1, slow = 1'b0;
  logic [5:0] pg = '0, fp = '0, flo = '0;
  logic       vld, rdy, rdv, cml, flt, alr;
  logic [7:0] rdd;
  logic [5:0] en, mlo, mhi, mact;
  onoff_pkg::cmd_t cmd;
  int         bad_count = 0, n_compared = 0;
  logic [7:0] cfx[4] = '{8'h16, 8'h16, 8'h17, 8'h16};
  logic [7:0] pgx[4] = '{8'h00, 8'h04, 8'h05, 8'h06};
  logic [7:0] lvl[4] = '{8'h80, 8'h40, 8'h20, 8'h00};
  logic [7:0] ops[5] = '{8'h94, 8'h98, 8'hA4, 8'hA8, 8'h80};
  always #5 clk = ~clk;
  pmbus_onoff_protect_config #(.TOFF_CYCLES(8), .STORE_CYCLES(5)) dut_u (
    .i_clock(clk), .i_sys_rst(rst), .i_cmd_valid(vld), .i_cmd(cmd), .o_cmd_ready(rdy),
    .o_rd_valid(rdv), .o_rd_data(rdd), .i_control_pin(pin), .i_bias_ok(bias),
    .i_pgood_on(pg), .i_fault_present(fp), .i_fault_latch_off(flo), .i_alert_enable(aen),
    .i_supply_low(slow), .o_supply_enable_output(en), .o_margin_low(mlo),
    .o_margin_high(mhi), .o_margin_act_fault(mact), .o_status_cml(cml),
    .o_status_fault(flt), .o_alert(alr));
  pmbus_host_model host_u (.i_clock(clk), .i_ready(rdy), .i_rd_valid(rdv),
    .i_rd_data(rdd), .o_valid(vld), .o_cmd(cmd));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] c, input logic [7:0] d,
                    output logic [7:0] r);
    logic ok;
    host_u.xfer(w, c, d, r, ok);
    if (!ok) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    xf(1'b1, c, d, r);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e, input string nm);
    logic [7:0] r;
    xf(1'b0, c, 8'h00, r);
    chk(nm, e, r);
  endtask
  task automatic wait_en(input logic [5:0] e, input int lim, input string nm);
    int n;
    n = 0;
    while (en !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(nm, {2'b00, e}, {2'b00, en});
    if (en !== e) end_of_test();
  endtask
  task automatic bit_is(input string nm, input logic e, input int s, input int k);
    logic [4:0] v;
    repeat (k) @(negedge clk);
    v = {flt, alr, mlo[0], en[0], cml};
    chk(nm, {7'h00, e}, {7'h00, v[s]});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(8'h02, 8'h16, "cfg_reset");
    rd(8'h10, 8'h00, "lock_reset");
    rd(8'h19, 8'h10, "feature");
    aen = 1'b0;
    rd(8'h19, 8'h00, "feature_noalert");
    aen = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, lvl[i]);
      wr(8'h00, 8'h03 + 8'(i));
      rd(8'h00, pgx[i], "page_lock");
      wr(8'h02, (i == 3) ? 8'h16 : 8'h17);
      rd(8'h02, cfx[i], "cfg_lock");
      rd(8'h10, lvl[i], "lock_read");
    end
    bit_is("no_fault", 1'b0, 0, 1);
    wr(8'h00, 8'h00);
    $display("test locks end");
    pin = 1'b1;
    wait_en(6'h3F, 40, "pin_on");
    wr(8'h01, 8'h00);
    bit_is("op_ignored", 1'b1, 1, 6);
    pg = 6'h3F;
    wr(8'h01, 8'h94);
    bit_is("margin_dis", 1'b1, 2, 3);
    wr(8'h01, 8'h80);
    pin = 1'b0;
    bit_is("soft_hold", 1'b1, 1, 4);
    wait_en(6'h00, 40, "soft_off");
    wr(8'h02, 8'h15);
    wait_en(6'h3F, 8, "low_pol_on");
    pin = 1'b1;
    wait_en(6'h00, 6, "imm_off");
    $display("test pin end");
    wr(8'h02, 8'h18);
    wr(8'h00, 8'hFF);
    wr(8'h01, 8'h00);
    wait_en(6'h00, 8, "op_needed");
    pg = 6'h00;
    wr(8'h01, 8'h80);
    wait_en(6'h3F, 8, "op_on");
    wr(8'h01, 8'h00);
    wait_en(6'h00, 4, "off_now");
    wr(8'h01, 8'h80);
    wait_en(6'h3F, 8, "op_on2");
    wr(8'h01, 8'h40);
    bit_is("soft_op_hold", 1'b1, 1, 4);
    wait_en(6'h00, 40, "soft_op_off");
    wr(8'h01, 8'h80);
    wait_en(6'h3F, 8, "on_again");
    wr(8'h01, 8'h94);
    bit_is("no_margin", 1'b0, 2, 4);
    pg = 6'h3F;
    for (int i = 0; i < 5; i++) begin
      wr(8'h01, ops[i]);
      repeat (3) @(negedge clk);
      chk("m_low", (i < 2) ? 8'h3F : 8'h00, {2'b00, mlo});
      chk("m_high", (i == 2 || i == 3) ? 8'h3F : 8'h00, {2'b00, mhi});
      chk("m_act", (i == 1 || i == 3) ? 8'h3F : 8'h00, {2'b00, mact});
    end
    $display("test operation end");
    wr(8'h01, 8'h55);
    bit_is("cml_bad_op", 1'b1, 0, 3);
    bit_is("alert_bad_op", 1'b1, 3, 0);
    wr(8'h03, 8'h00);
    bit_is("cml_cleared", 1'b0, 0, 3);
    bit_is("en_kept", 1'b1, 1, 0);
    fp = 6'h04;
    wr(8'h03, 8'h00);
    bit_is("refault", 1'b1, 4, 3);
    bit_is("realert", 1'b1, 3, 0);
    fp = 6'h00;
    wr(8'h03, 8'h00);
    bit_is("fault_gone", 1'b0, 4, 3);
    $display("test faults end");
    wr(8'h01, 8'h00);
    wait_en(6'h00, 4, "store_prep");
    wr(8'h02, 8'h1C);
    wr(8'h11, 8'h00);
    rd(8'h02, 8'h1C, "after_store");
    wr(8'h02, 8'h18);
    wr(8'h12, 8'h00);
    rd(8'h02, 8'h1C, "restored");
    slow = 1'b1;
    wr(8'h11, 8'h00);
    rd(8'h19, 8'h10, "busy_read");
    slow = 1'b0;
    bit_is("store_fail", 1'b1, 0, 1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h02, 8'h1C, "reset_restore");
    wr(8'h02, 8'h00);
    wait_en(6'h3F, 8, "bias_on");
    $display("test store end");
    end_of_test();
  end
endmodule
